/* design/dsw_cfg.svh */
// Register map, field positions, reset values and pattern constants of the data switch block
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH

// Management frame layout
`define DSW_DEVAD 5'h1e
`define DSW_PREAMBLE_BITS 6'd32
`define DSW_POS_HDR_LAST 5'd13
`define DSW_POS_TA1 5'd14
`define DSW_POS_TA2 5'd15
`define DSW_POS_DATA_FIRST 5'd16
`define DSW_POS_LAST 5'd31
`define DSW_OP_ADDR 2'b00
`define DSW_OP_WRITE 2'b01
`define DSW_OP_READ_INC 2'b10
`define DSW_OP_READ 2'b11

// Register offsets and reset values
`define DSW_REG_RX_SRC_MASK 16'h001a
`define DSW_REG_STATUS 16'h001b
`define DSW_RX_SRC_MASK_RST 16'h4c20
`define DSW_STATUS_RST 16'h1020
`define DSW_TX_SOURCE_RST 4'h1
`define DSW_RX_SOURCE_RST 4'h2

// Fields of the receive source and mask register
`define DSW_RX_SRC_MSB 15
`define DSW_RX_SRC_LSB 14
`define DSW_RX_MODE_MSB 13
`define DSW_RX_MODE_LSB 12
`define DSW_RX_MASK_MSB 7
`define DSW_RX_MASK_LSB 0

// Line patterns, byte lane 0 in the low bits
`define DSW_KR_IDLE_DATA 32'h07070707
`define DSW_KR_IDLE_CTRL 4'hf
`define DSW_KR_LF_DATA 32'h0100009c
`define DSW_KR_LF_CTRL 4'h1
`define DSW_KX_COMMA 8'hbc
`define DSW_KX_I1_DATA 8'hc5
`define DSW_KX_I2_DATA 8'h50
`define DSW_KX_I2_CTRL 4'h1
`define DSW_KX_ERR_DATA 32'h000000fe
`define DSW_KX_ERR_CTRL 4'h1

`endif

/* design/dsw_pkg.sv */
// Types and shared helper functions of the data switch block
package dsw_pkg;
`include "dsw_cfg.svh"

    typedef enum {DSW_SW_IDLE, DSW_SW_WAIT_OFF, DSW_SW_WAIT_ON, DSW_SW_MASK} dsw_sw_state_e;
    typedef enum {DSW_FR_PREAMBLE, DSW_FR_FRAME} dsw_frame_state_e;

    // Two-bit source code to one-hot status
    function automatic logic [3:0] dsw_onehot(input logic [1:0] sel);
        dsw_onehot = 4'h1 << sel;
    endfunction

    // Recognise an idle, local-fault or programmed character on the stream
    function automatic logic dsw_pattern_hit(input logic kx, input logic alt,
            input logic [7:0] match_char, input logic [31:0] data, input logic [3:0] ctrl);
        logic idle_kx;
        idle_kx = ctrl[0] && !ctrl[1] && (data[7:0] == `DSW_KX_COMMA) &&
            ((data[15:8] == `DSW_KX_I1_DATA) || (data[15:8] == `DSW_KX_I2_DATA));
        if (kx) begin
            dsw_pattern_hit = alt ? (data[7:0] == match_char) : idle_kx;
        end else if (alt) begin
            dsw_pattern_hit = (data == `DSW_KR_LF_DATA) && (ctrl == `DSW_KR_LF_CTRL);
        end else begin
            dsw_pattern_hit = (data == `DSW_KR_IDLE_DATA) && (ctrl == `DSW_KR_IDLE_CTRL);
        end
    endfunction
endpackage

/* design/dsw_engine.sv */
// One direction of the data switch: switch sequence, masking and fill pattern
`timescale 1ns/10ps
`include "dsw_cfg.svh"
module dsw_engine
    import dsw_pkg::*;
#(
    parameter logic [3:0] RESET_SOURCE = 4'h1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [1:0] target,
    input wire logic [1:0] mode,
    input wire logic [7:0] mask_cycles,
    input wire logic kx_mode,
    input wire logic on_sel,
    input wire logic off_sel,
    input wire logic [7:0] on_char,
    input wire logic [7:0] off_char,
    input wire logic fill_sel,
    input wire logic [31:0] data,
    input wire logic [3:0] ctrl,
    output logic [3:0] source_onehot,
    output logic waiting,
    output logic done_pulse,
    output logic on_pulse,
    output logic off_pulse,
    output logic fill_active,
    output logic [31:0] fill_data,
    output logic [3:0] fill_ctrl
);
    dsw_sw_state_e state;
    logic [1:0] pending_sel;
    logic [7:0] mask_cnt;
    logic off_ok;
    logic on_ok;

    assign off_ok = (mode[1] ^ mode[0]) || dsw_pattern_hit(kx_mode, off_sel, off_char, data, ctrl);
    assign on_ok = mode[1] || dsw_pattern_hit(kx_mode, on_sel, on_char, data, ctrl);
    assign waiting = (state != DSW_SW_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= DSW_SW_IDLE;
            pending_sel <= 2'b00;
            mask_cnt <= 8'h00;
            source_onehot <= RESET_SOURCE;
            done_pulse <= 1'b0;
            on_pulse <= 1'b0;
            off_pulse <= 1'b0;
            fill_active <= 1'b0;
        end else if (ce) begin
            done_pulse <= 1'b0;
            on_pulse <= 1'b0;
            off_pulse <= 1'b0;
            case (state)
                DSW_SW_IDLE: begin
                    if (dsw_onehot(target) != source_onehot) begin
                        pending_sel <= target;
                        state <= DSW_SW_WAIT_OFF;
                    end
                end
                DSW_SW_WAIT_OFF: begin
                    if (off_ok) begin
                        off_pulse <= 1'b1;
                        fill_active <= 1'b1;
                        state <= DSW_SW_WAIT_ON;
                    end
                end
                DSW_SW_WAIT_ON: begin
                    if (on_ok) begin
                        on_pulse <= 1'b1;
                        mask_cnt <= mask_cycles;
                        state <= DSW_SW_MASK;
                    end
                end
                DSW_SW_MASK: begin
                    if (mask_cnt <= 8'h01) begin
                        source_onehot <= dsw_onehot(pending_sel);
                        done_pulse <= 1'b1;
                        fill_active <= 1'b0;
                        state <= DSW_SW_IDLE;
                    end else begin
                        mask_cnt <= mask_cnt - 8'h01;
                    end
                end
                default: begin
                    state <= DSW_SW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fill_data <= `DSW_KR_IDLE_DATA;
            fill_ctrl <= `DSW_KR_IDLE_CTRL;
        end else if (ce) begin
            if (kx_mode) begin
                fill_data <= fill_sel ? `DSW_KX_ERR_DATA : {16'h0000, `DSW_KX_I2_DATA, `DSW_KX_COMMA};
                fill_ctrl <= fill_sel ? `DSW_KX_ERR_CTRL : `DSW_KX_I2_CTRL;
            end else begin
                fill_data <= fill_sel ? `DSW_KR_LF_DATA : `DSW_KR_IDLE_DATA;
                fill_ctrl <= fill_sel ? `DSW_KR_LF_CTRL : `DSW_KR_IDLE_CTRL;
            end
        end
    end
endmodule // dsw_engine

/* design/dsw_ctrl_status.sv */
// Data switch control and status registers behind the management serial port
`timescale 1ns/10ps
`include "dsw_cfg.svh"
module dsw_ctrl_status
    import dsw_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    input wire logic MDC,
    input wire logic MDIO_IN,
    output logic MDIO_OUT,
    output logic MDIO_OE,
    input wire logic [4:0] PORT_ADDR,
    input wire logic PIN_SWITCH_ENABLE,
    input wire logic [1:0] PIN_SOURCE_SELECT,
    input wire logic KX_MODE,
    input wire logic RX_ON_SEL,
    input wire logic RX_OFF_SEL,
    input wire logic [7:0] RX_ON_CHAR,
    input wire logic [7:0] RX_OFF_CHAR,
    input wire logic RX_FILL_PATTERN_SELECT,
    input wire logic [31:0] RX_DATA,
    input wire logic [3:0] RX_CTRL,
    input wire logic [1:0] TX_SOURCE_SELECT,
    input wire logic [1:0] TX_TRIGGER_MODE,
    input wire logic [7:0] TX_MASK_CYCLES,
    input wire logic TX_ON_SEL,
    input wire logic TX_OFF_SEL,
    input wire logic [7:0] TX_ON_CHAR,
    input wire logic [7:0] TX_OFF_CHAR,
    input wire logic TX_FILL_PATTERN_SELECT,
    input wire logic [31:0] TX_DATA,
    input wire logic [3:0] TX_CTRL,
    output logic [3:0] RX_SOURCE_ONEHOT,
    output logic RX_FILL_ACTIVE,
    output logic [31:0] RX_FILL_DATA,
    output logic [3:0] RX_FILL_CTRL,
    output logic [3:0] TX_SOURCE_ONEHOT,
    output logic TX_FILL_ACTIVE,
    output logic [31:0] TX_FILL_DATA,
    output logic [3:0] TX_FILL_CTRL
);
    // Management frame state
    dsw_frame_state_e frame_state;
    logic mdc_q;
    logic mdc_rise;
    logic [5:0] pre_cnt;
    logic [4:0] pos;
    logic [13:0] hdr;
    logic [14:0] wdata;
    logic [15:0] addr;
    logic [15:0] out_sr;
    logic frame_match;
    logic [1:0] op;
    logic rd_go;
    logic wr_commit;
    logic [15:0] wr_value;
    logic [15:0] rd_value;
    logic status_clr;

    // Register contents
    logic [15:0] rx_switch_source_and_mask;
    logic [1:0] rx_source_select;
    logic [1:0] rx_trigger_mode;
    logic [7:0] rx_mask_cycles;
    logic [1:0] rx_target;

    // Event flags
    logic tx_switch_waiting;
    logic rx_switch_waiting;
    logic tx_done_pulse;
    logic tx_on_pulse;
    logic tx_off_pulse;
    logic rx_done_pulse;
    logic rx_on_pulse;
    logic rx_off_pulse;
    logic tx_switch_complete;
    logic tx_resume_event;
    logic tx_halt_event;
    logic rx_switch_complete;
    logic rx_resume_event;
    logic rx_halt_event;
    logic [15:0] switch_status;

    // Management clock is sampled as an ordinary synchronous input
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mdc_q <= 1'b0;
        end else if (CE) begin
            mdc_q <= MDC;
        end
    end

    assign mdc_rise = MDC && !mdc_q;
    assign op = hdr[11:10];
    assign frame_match = (frame_state == DSW_FR_FRAME) && (hdr[13:12] == 2'b00) &&
        (hdr[9:5] == PORT_ADDR) && (hdr[4:0] == `DSW_DEVAD);
    assign rd_go = CE && mdc_rise && frame_match && (pos == `DSW_POS_TA1) && op[1];
    assign wr_commit = CE && mdc_rise && frame_match && (pos == `DSW_POS_LAST);
    assign wr_value = {wdata, MDIO_IN};

    // Frame framing: preamble count, header and write data capture
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            frame_state <= DSW_FR_PREAMBLE;
            pre_cnt <= 6'd0;
            pos <= 5'd0;
            hdr <= 14'h0000;
            wdata <= 15'h0000;
        end else if (CE && mdc_rise) begin
            case (frame_state)
                DSW_FR_PREAMBLE: begin
                    if (MDIO_IN) begin
                        if (pre_cnt != `DSW_PREAMBLE_BITS) begin
                            pre_cnt <= pre_cnt + 6'd1;
                        end
                    end else if (pre_cnt == `DSW_PREAMBLE_BITS) begin
                        frame_state <= DSW_FR_FRAME;
                        pos <= 5'd1;
                        hdr <= 14'h0000;
                    end else begin
                        pre_cnt <= 6'd0;
                    end
                end
                DSW_FR_FRAME: begin
                    pos <= pos + 5'd1;
                    if (pos <= `DSW_POS_HDR_LAST) begin
                        hdr <= {hdr[12:0], MDIO_IN};
                    end
                    if (pos >= `DSW_POS_DATA_FIRST) begin
                        wdata <= {wdata[13:0], MDIO_IN};
                    end
                    if ((pos == 5'd1 && MDIO_IN) || pos == `DSW_POS_LAST) begin
                        frame_state <= DSW_FR_PREAMBLE;
                        pre_cnt <= 6'd0;
                        pos <= 5'd0;
                    end
                end
                default: begin
                    frame_state <= DSW_FR_PREAMBLE;
                    pre_cnt <= 6'd0;
                end
            endcase
        end
    end

    // Address register, with post-read increment
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            addr <= 16'h0000;
        end else if (wr_commit && op == `DSW_OP_ADDR) begin
            addr <= wr_value;
        end else if (rd_go && op == `DSW_OP_READ_INC) begin
            addr <= addr + 16'h0001;
        end
    end

    // Receive source and mask register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rx_switch_source_and_mask <= `DSW_RX_SRC_MASK_RST;
        end else if (wr_commit && op == `DSW_OP_WRITE && addr == `DSW_REG_RX_SRC_MASK) begin
            rx_switch_source_and_mask <= wr_value;
        end
    end

    assign rx_source_select = rx_switch_source_and_mask[`DSW_RX_SRC_MSB:`DSW_RX_SRC_LSB];
    assign rx_trigger_mode = rx_switch_source_and_mask[`DSW_RX_MODE_MSB:`DSW_RX_MODE_LSB];
    assign rx_mask_cycles = rx_switch_source_and_mask[`DSW_RX_MASK_MSB:`DSW_RX_MASK_LSB];
    assign rx_target = PIN_SWITCH_ENABLE ? PIN_SOURCE_SELECT : rx_source_select;

    // Read data and turnaround drive
    always_comb begin
        if (addr == `DSW_REG_RX_SRC_MASK) begin
            rd_value = rx_switch_source_and_mask;
        end else if (addr == `DSW_REG_STATUS) begin
            rd_value = switch_status;
        end else begin
            rd_value = 16'h0000;
        end
    end

    assign status_clr = rd_go && (addr == `DSW_REG_STATUS);

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            MDIO_OUT <= 1'b0;
            MDIO_OE <= 1'b0;
            out_sr <= 16'h0000;
        end else if (CE && mdc_rise) begin
            if (rd_go) begin
                MDIO_OE <= 1'b1;
                MDIO_OUT <= 1'b0;
                out_sr <= rd_value;
            end else if (MDIO_OE && pos >= `DSW_POS_TA2 && pos < `DSW_POS_LAST) begin
                MDIO_OUT <= out_sr[15];
                out_sr <= {out_sr[14:0], 1'b0};
            end else begin
                MDIO_OE <= 1'b0;
                MDIO_OUT <= 1'b0;
            end
        end
    end

    // Latching-high flags; a new event wins over the clear-on-read
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            tx_switch_complete <= 1'b0;
            tx_resume_event <= 1'b0;
            tx_halt_event <= 1'b0;
        end else if (CE) begin
            tx_switch_complete <= tx_done_pulse || (tx_switch_complete && !status_clr);
            tx_resume_event <= tx_on_pulse || (tx_resume_event && !status_clr);
            tx_halt_event <= tx_off_pulse || (tx_halt_event && !status_clr);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rx_switch_complete <= 1'b0;
            rx_resume_event <= 1'b0;
            rx_halt_event <= 1'b0;
        end else if (CE) begin
            rx_switch_complete <= rx_done_pulse || (rx_switch_complete && !status_clr);
            rx_resume_event <= rx_on_pulse || (rx_resume_event && !status_clr);
            rx_halt_event <= rx_off_pulse || (rx_halt_event && !status_clr);
        end
    end

    assign switch_status = {
        TX_SOURCE_ONEHOT,
        tx_switch_waiting,
        tx_switch_complete,
        tx_resume_event,
        tx_halt_event,
        RX_SOURCE_ONEHOT,
        rx_switch_waiting,
        rx_switch_complete,
        rx_resume_event,
        rx_halt_event
    };

    dsw_engine #(
        .RESET_SOURCE(`DSW_TX_SOURCE_RST)
    ) u_tx_engine (
        .clk(CLK_SYS),
        .srst(SRST),
        .ce(CE),
        .target(TX_SOURCE_SELECT),
        .mode(TX_TRIGGER_MODE),
        .mask_cycles(TX_MASK_CYCLES),
        .kx_mode(KX_MODE),
        .on_sel(TX_ON_SEL),
        .off_sel(TX_OFF_SEL),
        .on_char(TX_ON_CHAR),
        .off_char(TX_OFF_CHAR),
        .fill_sel(TX_FILL_PATTERN_SELECT),
        .data(TX_DATA),
        .ctrl(TX_CTRL),
        .source_onehot(TX_SOURCE_ONEHOT),
        .waiting(tx_switch_waiting),
        .done_pulse(tx_done_pulse),
        .on_pulse(tx_on_pulse),
        .off_pulse(tx_off_pulse),
        .fill_active(TX_FILL_ACTIVE),
        .fill_data(TX_FILL_DATA),
        .fill_ctrl(TX_FILL_CTRL)
    );

    dsw_engine #(
        .RESET_SOURCE(`DSW_RX_SOURCE_RST)
    ) u_rx_engine (
        .clk(CLK_SYS),
        .srst(SRST),
        .ce(CE),
        .target(rx_target),
        .mode(rx_trigger_mode),
        .mask_cycles(rx_mask_cycles),
        .kx_mode(KX_MODE),
        .on_sel(RX_ON_SEL),
        .off_sel(RX_OFF_SEL),
        .on_char(RX_ON_CHAR),
        .off_char(RX_OFF_CHAR),
        .fill_sel(RX_FILL_PATTERN_SELECT),
        .data(RX_DATA),
        .ctrl(RX_CTRL),
        .source_onehot(RX_SOURCE_ONEHOT),
        .waiting(rx_switch_waiting),
        .done_pulse(rx_done_pulse),
        .on_pulse(rx_on_pulse),
        .off_pulse(rx_off_pulse),
        .fill_active(RX_FILL_ACTIVE),
        .fill_data(RX_FILL_DATA),
        .fill_ctrl(RX_FILL_CTRL)
    );
endmodule // dsw_ctrl_status

/* test/dsw_ctrl_status_checker.sv */
// Concurrent checks on the ports of the data switch control and status block
`timescale 1ns/10ps
`include "dsw_cfg.svh"
module dsw_ctrl_status_checker (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    input wire logic KX_MODE,
    input wire logic RX_FILL_PATTERN_SELECT,
    input wire logic TX_FILL_PATTERN_SELECT,
    input wire logic [1:0] TX_SOURCE_SELECT,
    input wire logic [1:0] TX_TRIGGER_MODE,
    input wire logic [7:0] TX_MASK_CYCLES,
    input wire logic [3:0] RX_SOURCE_ONEHOT,
    input wire logic RX_FILL_ACTIVE,
    input wire logic [31:0] RX_FILL_DATA,
    input wire logic [3:0] RX_FILL_CTRL,
    input wire logic [3:0] TX_SOURCE_ONEHOT,
    input wire logic TX_FILL_ACTIVE,
    input wire logic [31:0] TX_FILL_DATA,
    input wire logic [3:0] TX_FILL_CTRL
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    logic [8:0] tx_run;
    logic [8:0] tx_expect;

    function automatic logic [35:0] fill_word(input logic kx, input logic sel);
        if (kx) begin
            fill_word = sel ? {`DSW_KX_ERR_DATA, `DSW_KX_ERR_CTRL} :
                {16'h0000, `DSW_KX_I2_DATA, `DSW_KX_COMMA, `DSW_KX_I2_CTRL};
        end else begin
            fill_word = sel ? {`DSW_KR_LF_DATA, `DSW_KR_LF_CTRL} :
                {`DSW_KR_IDLE_DATA, `DSW_KR_IDLE_CTRL};
        end
    endfunction

    // Length of the current transmit fill run, in cycles
    always_ff @(posedge CLK_SYS) begin
        if (SRST || !TX_FILL_ACTIVE) begin
            tx_run <= 9'h000;
        end else if (CE) begin
            tx_run <= tx_run + 9'h001;
        end
    end
    // Mask counts 0 and 1 both give one masking cycle after the ON cycle
    assign tx_expect = (TX_MASK_CYCLES == 8'h00) ? 9'h002 : {1'b0, TX_MASK_CYCLES} + 9'h001;

    sequence s_tx_target_moved;
        !TX_FILL_ACTIVE && (TX_SOURCE_ONEHOT != (4'h1 << TX_SOURCE_SELECT)) &&
            (TX_TRIGGER_MODE == 2'b01 || TX_TRIGGER_MODE == 2'b10);
    endsequence
    sequence s_tx_fill_ends_on_any;
        $fell(TX_FILL_ACTIVE) ##0 TX_TRIGGER_MODE[1];
    endsequence

    property p_tx_onehot;
        $onehot(TX_SOURCE_ONEHOT);
    endproperty
    property p_rx_onehot;
        $onehot(RX_SOURCE_ONEHOT);
    endproperty
    property p_tx_src_at_end;
        $changed(TX_SOURCE_ONEHOT) |-> $fell(TX_FILL_ACTIVE);
    endproperty
    property p_rx_src_at_end;
        $changed(RX_SOURCE_ONEHOT) |-> $fell(RX_FILL_ACTIVE);
    endproperty
    property p_tx_off_any;
        s_tx_target_moved |-> ##[1:3] TX_FILL_ACTIVE;
    endproperty
    property p_tx_fill_len;
        s_tx_fill_ends_on_any |-> tx_run == tx_expect;
    endproperty
    property p_tx_fill_word;
        1'b1 |=> {TX_FILL_DATA, TX_FILL_CTRL} ==
            fill_word($past(KX_MODE), $past(TX_FILL_PATTERN_SELECT));
    endproperty
    property p_rx_fill_word;
        1'b1 |=> {RX_FILL_DATA, RX_FILL_CTRL} ==
            fill_word($past(KX_MODE), $past(RX_FILL_PATTERN_SELECT));
    endproperty

    a_tx_onehot: assert property (p_tx_onehot)
        else $error("transmit source not one-hot");
    a_rx_onehot: assert property (p_rx_onehot)
        else $error("receive source not one-hot");
    a_tx_src_at_end: assert property (p_tx_src_at_end)
        else $error("transmit source changed outside fill end");
    a_rx_src_at_end: assert property (p_rx_src_at_end)
        else $error("receive source changed outside fill end");
    a_tx_off_any: assert property (p_tx_off_any)
        else $error("transmit fill did not start on any-data OFF");
    a_tx_fill_len: assert property (p_tx_fill_len)
        else $error("transmit fill run length wrong");
    a_tx_fill_word: assert property (p_tx_fill_word)
        else $error("transmit fill word wrong");
    a_rx_fill_word: assert property (p_rx_fill_word)
        else $error("receive fill word wrong");
endmodule // dsw_ctrl_status_checker

bind dsw_ctrl_status dsw_ctrl_status_checker u_dsw_ctrl_status_checker (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .KX_MODE(KX_MODE),
    .RX_FILL_PATTERN_SELECT(RX_FILL_PATTERN_SELECT),
    .TX_FILL_PATTERN_SELECT(TX_FILL_PATTERN_SELECT), .TX_SOURCE_SELECT(TX_SOURCE_SELECT),
    .TX_TRIGGER_MODE(TX_TRIGGER_MODE), .TX_MASK_CYCLES(TX_MASK_CYCLES),
    .RX_SOURCE_ONEHOT(RX_SOURCE_ONEHOT), .RX_FILL_ACTIVE(RX_FILL_ACTIVE),
    .RX_FILL_DATA(RX_FILL_DATA), .RX_FILL_CTRL(RX_FILL_CTRL),
    .TX_SOURCE_ONEHOT(TX_SOURCE_ONEHOT), .TX_FILL_ACTIVE(TX_FILL_ACTIVE),
    .TX_FILL_DATA(TX_FILL_DATA), .TX_FILL_CTRL(TX_FILL_CTRL));

/* test/dsw_mdio_station.sv */
// Management station model that sends serial management frames
`timescale 1ns/10ps
module dsw_mdio_station #(
    parameter logic [4:0] PRTAD = 5'h03
) (
    input wire logic clk,
    output logic mdc,
    output logic drv_en,
    output logic drv_bit,
    input wire logic mdio
);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b1;
    end

    // Preamble, header, then data; the line is released over turnaround and data of a read
    task automatic frame(input logic [1:0] op, input logic [15:0] d, output logic [15:0] q);
        logic [31:0] hdr;
        hdr = {2'b00, op, PRTAD, 5'h1e, 2'b10, d};
        q = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            mdc = 1'b0;
            drv_en = !(op[1] && i >= 46);
            drv_bit = (i < 32) ? 1'b1 : hdr[63 - i];
            @(negedge clk);
            if (op[1] && i >= 48) begin
                q = {q[14:0], mdio};
            end
            mdc = 1'b1;
        end
        @(negedge clk);
        mdc = 1'b0;
        drv_en = 1'b0;
    endtask
endmodule // dsw_mdio_station

/* test/dsw_ctrl_status_tb_top.sv */
// Self-checking testbench of the data switch control and status block
`timescale 1ns/10ps
module dsw_ctrl_status_tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic mdc, st_en, st_bit, mdio_out, mdio_oe, rx_fill, tx_fill;
    logic kx = 1'b0;
    logic pin_en = 1'b0;
    logic [1:0] pin_sel = 2'b01;
    logic rx_on_sel = 1'b0;
    logic rx_off_sel = 1'b0;
    logic [7:0] rx_on_char = 8'h00;
    logic [7:0] rx_off_char = 8'h00;
    logic rx_fill_sel = 1'b0;
    logic [31:0] rx_data = 32'h0;
    logic [3:0] rx_ctrl = 4'h0;
    logic [1:0] tx_sel = 2'b00;
    logic [1:0] tx_mode = 2'b00;
    logic [7:0] tx_mask = 8'h20;
    logic tx_on_sel = 1'b0;
    logic [7:0] tx_on_char = 8'h00;
    logic tx_fill_sel = 1'b0;
    logic [31:0] tx_data = 32'h0;
    logic [3:0] tx_ctrl = 4'h0;
    logic [3:0] rx_src, tx_src;
    logic [31:0] rx_fill_data;
    int errors = 0;
    int checks = 0;
    // Pull-up holds the line high when nobody drives it
    wire mdio_line = mdio_oe ? mdio_out : (st_en ? st_bit : 1'b1);

    always #10 clk_sys = ~clk_sys;

    dsw_mdio_station #(.PRTAD(5'h03)) u_dsw_mdio_station (.clk(clk_sys), .mdc(mdc),
        .drv_en(st_en), .drv_bit(st_bit), .mdio(mdio_line));

    dsw_ctrl_status u_dsw_ctrl_status (.CLK_SYS(clk_sys), .SRST(srst), .CE(ce), .MDC(mdc),
        .MDIO_IN(mdio_line), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe), .PORT_ADDR(5'h03),
        .PIN_SWITCH_ENABLE(pin_en), .PIN_SOURCE_SELECT(pin_sel), .KX_MODE(kx),
        .RX_ON_SEL(rx_on_sel), .RX_OFF_SEL(rx_off_sel), .RX_ON_CHAR(rx_on_char),
        .RX_OFF_CHAR(rx_off_char), .RX_FILL_PATTERN_SELECT(rx_fill_sel), .RX_DATA(rx_data),
        .RX_CTRL(rx_ctrl), .TX_SOURCE_SELECT(tx_sel), .TX_TRIGGER_MODE(tx_mode),
        .TX_MASK_CYCLES(tx_mask), .TX_ON_SEL(tx_on_sel), .TX_OFF_SEL(1'b0),
        .TX_ON_CHAR(tx_on_char), .TX_OFF_CHAR(8'h00), .TX_FILL_PATTERN_SELECT(tx_fill_sel),
        .TX_DATA(tx_data), .TX_CTRL(tx_ctrl), .RX_SOURCE_ONEHOT(rx_src),
        .RX_FILL_ACTIVE(rx_fill), .RX_FILL_DATA(rx_fill_data), .RX_FILL_CTRL(),
        .TX_SOURCE_ONEHOT(tx_src), .TX_FILL_ACTIVE(tx_fill), .TX_FILL_DATA(), .TX_FILL_CTRL());

    task automatic end_of_test;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] q;
        u_dsw_mdio_station.frame(2'b00, a, q);
        u_dsw_mdio_station.frame(2'b01, d, q);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] q;
        u_dsw_mdio_station.frame(2'b00, a, q);
        u_dsw_mdio_station.frame(2'b11, 16'h0000, q);
        chk(q, exp);
    endtask

    // Counts falling edges until the chosen fill flag reaches the level
    task automatic wait_fill(input logic rx, input logic lvl, output int n);
        n = 0;
        while ((rx ? rx_fill : tx_fill) !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > 400) begin
                errors++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, !lvl, lvl);
                end_of_test;
            end
        end
    endtask

    task automatic t_reset_values;
        logic [15:0] q;
        u_dsw_mdio_station.frame(2'b00, 16'h001a, q);
        u_dsw_mdio_station.frame(2'b10, 16'h0000, q);
        chk(q, 16'h4c20);
        u_dsw_mdio_station.frame(2'b11, 16'h0000, q);
        chk(q, 16'h1020);
        rd_chk(16'h001c, 16'h0000);
    endtask

    task automatic t_rx_any;
        int n;
        wr(16'h001a, 16'hec08);
        wait_fill(1'b1, 1'b1, n);
        wait_fill(1'b1, 1'b0, n);
        chk(16'(n), 16'h0009);
        chk(16'(rx_src), 16'h0008);
        rd_chk(16'h001b, 16'h1087);
        rd_chk(16'h001b, 16'h1080);
    endtask

    task automatic t_rx_pattern;
        int n;
        wr(16'h001a, 16'h0c00);
        repeat (20) @(negedge clk_sys);
        chk(16'(rx_fill), 16'h0000);
        rd_chk(16'h001b, 16'h1088);
        rx_data = 32'h07070707;
        rx_ctrl = 4'hf;
        @(negedge clk_sys);
        rx_data = 32'h0;
        repeat (10) @(negedge clk_sys);
        chk(16'(rx_fill), 16'h0001);
        rx_data = 32'h07070707;
        wait_fill(1'b1, 1'b0, n);
        chk(16'(rx_src), 16'h0001);
        rd_chk(16'h001b, 16'h1017);
    endtask

    task automatic t_rx_pin;
        int n;
        rx_data = 32'h0;
        kx = 1'b1;
        rx_on_sel = 1'b1;
        rx_off_sel = 1'b1;
        rx_on_char = 8'h5a;
        rx_off_char = 8'h5a;
        pin_en = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk(16'(rx_fill), 16'h0000);
        rx_data = 32'h0000005a;
        wait_fill(1'b1, 1'b1, n);
        wait_fill(1'b1, 1'b0, n);
        chk(16'(rx_src), 16'h0002);
    endtask

    task automatic t_tx_pattern_off;
        int n;
        kx = 1'b0;
        tx_data = 32'h07070707;
        tx_ctrl = 4'hf;
        tx_mode = 2'b11;
        tx_mask = 8'h05;
        tx_sel = 2'b10;
        wait_fill(1'b0, 1'b1, n);
        // Clock enable low must freeze the switch mid-sequence
        ce = 1'b0;
        repeat (20) @(negedge clk_sys);
        ce = 1'b1;
        wait_fill(1'b0, 1'b0, n);
        chk(16'(n), 16'h0006);
        chk(16'(tx_src), 16'h0004);
        rd_chk(16'h001b, 16'h4727);
    endtask

    task automatic t_tx_char_on;
        int n;
        kx = 1'b1;
        tx_on_sel = 1'b1;
        tx_on_char = 8'h3c;
        tx_data = 32'h0;
        tx_mask = 8'h00;
        tx_mode = 2'b01;
        tx_sel = 2'b01;
        wait_fill(1'b0, 1'b1, n);
        repeat (10) @(negedge clk_sys);
        chk(16'(tx_fill), 16'h0001);
        rd_chk(16'h001b, 16'h4920);
        tx_data = 32'h0000003c;
        wait_fill(1'b0, 1'b0, n);
        chk(16'(tx_src), 16'h0002);
        wr(16'h001b, 16'hffff);
        rd_chk(16'h001b, 16'h2620);
    endtask

    task automatic t_fill_words;
        for (int i = 0; i < 4; i++) begin
            kx = i[1];
            rx_fill_sel = i[0];
            tx_fill_sel = !i[0];
            repeat (2) @(negedge clk_sys);
        end
        chk(rx_fill_data[15:0], 16'h00fe);
    endtask

    initial begin
        repeat (8) @(negedge clk_sys);
        srst = 1'b0;
        t_reset_values;
        t_rx_any;
        t_rx_pattern;
        t_rx_pin;
        t_tx_pattern_off;
        t_tx_char_on;
        t_fill_words;
        end_of_test;
    end
endmodule // dsw_ctrl_status_tb_top
